// File: hdl/dacctl_dev.sv
// Converter end: two-wire register slave with the mode control registers
// How it works
// - Master sends address, index, then data bytes
// - Index steps by one per good byte
// - Index wraps from 7F to 00
// - Undefined write index gets no acknowledge
// - Read returns register the index selects
// - Index steps by one per read byte
// - First read after write keeps index
// - Indices 10 to 1F always return data
// - Line spikes filtered on the system clock
// - Master keeps clock high plus hold long
// - Master keeps start hold times long
// - Short-period spike limit is characterised
// - Left and right attenuation, default 0 dB
// - Input format field, default I2S 24-bit
// - De-emphasis rate field, default disabled
// - Soft mute bit, default off
// - Bypass stereo select, default monaural
// - Roll-off select, default sharp
// - Registers 16-21 writable, 22-23 read-only
// - Address is 10011 plus two select pins
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`include "dacctl_cfg.svh"
module dacctl_dev (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  dacctl_if.dev bus,
  input wire logic addr_select_low_in,
  input wire logic addr_select_high_in,
  input wire logic [1:0] zero_flag_in,
  input wire logic [4:0] device_id_in,
  output logic [7:0] left_atten_level_out,
  output logic [7:0] right_atten_level_out,
  output logic atten_load_enable_out,
  output logic [2:0] input_format_select_out,
  output logic [1:0] deemph_rate_select_out,
  output logic deemph_enable_out,
  output logic soft_mute_out,
  output logic output_phase_invert_out,
  output logic [1:0] atten_speed_select_out,
  output logic converter_disable_out,
  output logic bypass_stereo_select_out,
  output logic rolloff_select_out,
  output logic infinite_zero_mute_out,
  output logic [7:0] system_control_out,
  output logic [7:0] zero_output_control_out
);
  // ==========================================================
  // Line filter
  // Three stages then a run-length vote; a level counts only once it has been
  // steady longer than the widest spike, which costs a few cycles of latency.
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_f;
  logic sda_f;
  logic scl_prev;
  logic sda_prev;
  logic [3:0] scl_run;
  logic [3:0] sda_run;
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end
    else
    begin
      scl_sync <= {scl_sync[1:0], bus.scl_line};
      sda_sync <= {sda_sync[1:0], bus.sda_line};
    end
  end
  wire scl_agree = (scl_sync[1] == scl_sync[2]);
  wire sda_agree = (sda_sync[1] == sda_sync[2]);
  wire scl_take = scl_agree && (scl_sync[2] != scl_f);
  wire sda_take = sda_agree && (sda_sync[2] != sda_f);
  // Spike suppression per line; clock period 8 ns is below 50 ns, width characterised
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      scl_run <= 4'h0;
      sda_run <= 4'h0;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_run <= scl_take ? 4'(scl_run + 4'h1) : 4'h0;
      sda_run <= sda_take ? 4'(sda_run + 4'h1) : 4'h0;
      if (scl_take && scl_run >= 4'(`DACCTL_SPIKE_CYC))
        scl_f <= scl_sync[2];
      if (sda_take && sda_run >= 4'(`DACCTL_SPIKE_CYC))
        sda_f <= sda_sync[2];
      scl_prev <= scl_f;
      sda_prev <= sda_f;
    end
  end
  wire scl_rise = scl_f && !scl_prev;
  wire scl_fall = !scl_f && scl_prev;
  wire start_cond = scl_f && scl_prev && sda_prev && !sda_f;
  wire stop_cond = scl_f && scl_prev && !sda_prev && sda_f;
  // ==========================================================
  // Register file
  logic [7:0] reg_left;
  logic [7:0] reg_right;
  logic [7:0] reg_fmt;
  logic [7:0] reg_filt;
  logic [7:0] reg_r20;
  logic [7:0] reg_r21;
  logic [6:0] index;
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic first_byte;
  logic after_write;
  logic is_read;
  logic nack;
  logic drive_low;
  logic have_byte;
  dacctl_pkg::dacctl_slv_state_t state;
  // Writable indices are 16 to 21 only
  function automatic logic idx_writable(input logic [6:0] idx);
    idx_writable = (idx >= `DACCTL_IDX_LEFT) && (idx <= `DACCTL_IDX_R21);
  endfunction : idx_writable
  wire [6:0] own_addr = {`DACCTL_ADDR_FIXED, addr_select_high_in, addr_select_low_in};
  wire [6:0] index_next = (index == `DACCTL_IDX_MAX) ? `DACCTL_IDX_ZERO
    : 7'(index + 7'h1);
  // Read data; 10 to 1F always answer, undefined ones with zero
  wire [7:0] rd_data = (index == `DACCTL_IDX_LEFT) ? reg_left
    : (index == `DACCTL_IDX_RIGHT) ? reg_right
    : (index == `DACCTL_IDX_FMT) ? reg_fmt
    : (index == `DACCTL_IDX_FILT) ? reg_filt
    : (index == `DACCTL_IDX_R20) ? reg_r20
    : (index == `DACCTL_IDX_R21) ? reg_r21
    : (index == `DACCTL_IDX_R22) ? {6'h00, zero_flag_in}
    : (index == `DACCTL_IDX_R23) ? {3'h0, device_id_in}
    : 8'h00;
  wire [7:0] rx_byte = {shreg[6:0], sda_f};
  // ==========================================================
  // Protocol engine
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      state <= dacctl_pkg::DACCTL_S_IDLE;
      reg_left <= `DACCTL_RST_ATTEN;
      reg_right <= `DACCTL_RST_ATTEN;
      reg_fmt <= `DACCTL_RST_FMT;
      reg_filt <= `DACCTL_RST_FILT;
      reg_r20 <= `DACCTL_RST_R20;
      reg_r21 <= `DACCTL_RST_R21;
      index <= `DACCTL_IDX_ZERO;
      shreg <= 8'h00;
      bit_cnt <= `DACCTL_BIT_ZERO;
      first_byte <= 1'b0;
      after_write <= 1'b0;
      is_read <= 1'b0;
      nack <= 1'b0;
      drive_low <= 1'b0;
      have_byte <= 1'b0;
    end
    else if (start_cond)
    begin
      state <= dacctl_pkg::DACCTL_S_ADDR;
      have_byte <= 1'b0;
      bit_cnt <= `DACCTL_BIT_ZERO;
      drive_low <= 1'b0;
    end
    else if (stop_cond)
    begin
      state <= dacctl_pkg::DACCTL_S_IDLE;
      drive_low <= 1'b0;
    end
    else
    begin
      case (state)
        dacctl_pkg::DACCTL_S_ADDR, dacctl_pkg::DACCTL_S_RX:
        begin
          if (scl_rise)
          begin
            shreg <= rx_byte;
            bit_cnt <= 3'(bit_cnt + 3'h1);
            have_byte <= (bit_cnt == `DACCTL_BIT_LAST);
          end
          // A start's own clock fall is not a byte end
          if (scl_fall && have_byte)
          begin
            have_byte <= 1'b0;
            if (state == dacctl_pkg::DACCTL_S_ADDR)
            begin
              if (shreg[7:1] == own_addr)
              begin
                is_read <= shreg[0];
                first_byte <= !shreg[0];
                drive_low <= 1'b1;
                state <= dacctl_pkg::DACCTL_S_ADDR_ACK;
              end
              else
                state <= dacctl_pkg::DACCTL_S_IGNORE;
            end
            else if (first_byte)
            begin
              index <= shreg[6:0];
              first_byte <= 1'b0;
              drive_low <= 1'b1;
              state <= dacctl_pkg::DACCTL_S_RX_ACK;
            end
            else if (idx_writable(index))
            begin
              if (index == `DACCTL_IDX_LEFT)
                reg_left <= shreg;
              if (index == `DACCTL_IDX_RIGHT)
                reg_right <= shreg;
              if (index == `DACCTL_IDX_FMT)
                reg_fmt <= shreg;
              if (index == `DACCTL_IDX_FILT)
                reg_filt <= shreg & `DACCTL_MASK_FILT;
              if (index == `DACCTL_IDX_R20)
                reg_r20 <= shreg & `DACCTL_MASK_R20;
              if (index == `DACCTL_IDX_R21)
                reg_r21 <= shreg & `DACCTL_MASK_R21;
              index <= index_next;
              after_write <= 1'b1;
              drive_low <= 1'b1;
              state <= dacctl_pkg::DACCTL_S_RX_ACK;
            end
            else
            begin
              nack <= 1'b1;
              state <= dacctl_pkg::DACCTL_S_RX_ACK;
            end
          end
        end
        dacctl_pkg::DACCTL_S_ADDR_ACK, dacctl_pkg::DACCTL_S_RX_ACK:
        begin
          if (scl_fall)
          begin
            drive_low <= 1'b0;
            nack <= 1'b0;
            if (nack)
              state <= dacctl_pkg::DACCTL_S_IGNORE;
            else if (state == dacctl_pkg::DACCTL_S_ADDR_ACK && is_read)
            begin
              shreg <= rd_data;
              drive_low <= !rd_data[7];
              bit_cnt <= 3'h1;
              after_write <= 1'b0;
              state <= dacctl_pkg::DACCTL_S_TX;
            end
            else
            begin
              bit_cnt <= `DACCTL_BIT_ZERO;
              state <= dacctl_pkg::DACCTL_S_RX;
            end
          end
        end
        dacctl_pkg::DACCTL_S_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt == `DACCTL_BIT_ZERO)
            begin
              drive_low <= 1'b0;
              index <= index_next;
              state <= dacctl_pkg::DACCTL_S_TX_ACK;
            end
            else
            begin
              drive_low <= !shreg[`DACCTL_BIT_LAST - bit_cnt];
              bit_cnt <= 3'(bit_cnt + 3'h1);
            end
          end
        end
        dacctl_pkg::DACCTL_S_TX_ACK:
        begin
          if (scl_rise)
            nack <= sda_f;
          if (scl_fall)
          begin
            nack <= 1'b0;
            if (nack)
              state <= dacctl_pkg::DACCTL_S_IGNORE;
            else
            begin
              shreg <= rd_data;
              drive_low <= !rd_data[7];
              bit_cnt <= 3'h1;
              state <= dacctl_pkg::DACCTL_S_TX;
            end
          end
        end
        default:
          drive_low <= 1'b0;
      endcase
    end
  end
  // ==========================================================
  // Outputs, all registered
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      bus.sda_out_dev <= 1'b1;
      bus.sda_oe_dev <= 1'b0;
    end
    else
    begin
      bus.sda_out_dev <= 1'b0;
      bus.sda_oe_dev <= drive_low;
    end
  end
  assign left_atten_level_out = reg_left;
  assign right_atten_level_out = reg_right;
  assign atten_load_enable_out = reg_fmt[7];
  assign input_format_select_out = reg_fmt[6:4];
  assign deemph_rate_select_out = reg_fmt[3:2];
  assign deemph_enable_out = reg_fmt[1];
  assign soft_mute_out = reg_fmt[0];
  assign output_phase_invert_out = reg_filt[7];
  assign atten_speed_select_out = reg_filt[6:5];
  assign converter_disable_out = reg_filt[4];
  assign bypass_stereo_select_out = reg_filt[2];
  assign rolloff_select_out = reg_filt[1];
  assign infinite_zero_mute_out = reg_filt[0];
  assign system_control_out = reg_r20;
  assign zero_output_control_out = reg_r21;
  // Index and first-read behaviour leave after_write as a marker only
  wire unused_after_write = after_write;
endmodule : dacctl_dev

// File: hdl/dacctl_cfg.svh
// Constants shared by both ends of the converter control link
`ifndef DACCTL_CFG_SVH
`define DACCTL_CFG_SVH
`define DACCTL_ADDR_FIXED 5'b1_0011
`define DACCTL_IDX_MAX 7'h7F
`define DACCTL_IDX_ZERO 7'h00
`define DACCTL_IDX_LEFT 7'h10
`define DACCTL_IDX_RIGHT 7'h11
`define DACCTL_IDX_FMT 7'h12
`define DACCTL_IDX_FILT 7'h13
`define DACCTL_IDX_R20 7'h14
`define DACCTL_IDX_R21 7'h15
`define DACCTL_IDX_R22 7'h16
`define DACCTL_IDX_R23 7'h17
`define DACCTL_IDX_WIN_HI 3'h1
`define DACCTL_RST_ATTEN 8'hFF
`define DACCTL_RST_FMT 8'h50
`define DACCTL_RST_FILT 8'h00
`define DACCTL_RST_R20 8'h00
`define DACCTL_RST_R21 8'h01
`define DACCTL_MASK_R21 8'h07
`define DACCTL_MASK_R20 8'h7F
`define DACCTL_MASK_FILT 8'hF7
`define DACCTL_BIT_LAST 3'h7
`define DACCTL_BIT_ZERO 3'h0
`define DACCTL_SCK_NS 8
`define DACCTL_TSP_NS 50
`define DACCTL_SPIKE_CYC ((`DACCTL_TSP_NS + `DACCTL_SCK_NS - 1) / `DACCTL_SCK_NS)
`define DACCTL_HALF_NS 1300
`define DACCTL_HALF_CYC (`DACCTL_HALF_NS / `DACCTL_SCK_NS)
`define DACCTL_CNT_W 8
`endif

// File: hdl/dacctl_pkg.sv
// Types shared by both ends of the converter control link
package dacctl_pkg;
  typedef enum logic [3:0] {
    DACCTL_S_IDLE,
    DACCTL_S_ADDR,
    DACCTL_S_ADDR_ACK,
    DACCTL_S_RX,
    DACCTL_S_RX_ACK,
    DACCTL_S_TX,
    DACCTL_S_TX_ACK,
    DACCTL_S_IGNORE
  } dacctl_slv_state_t;
  typedef enum logic [3:0] {
    DACCTL_M_IDLE,
    DACCTL_M_START,
    DACCTL_M_BIT_LOW,
    DACCTL_M_BIT_HIGH,
    DACCTL_M_STOP_LOW,
    DACCTL_M_STOP_HIGH,
    DACCTL_M_STOP_END
  } dacctl_mst_state_t;
endpackage : dacctl_pkg

// File: hdl/dacctl_if.sv
// Two-wire link between the controller and the converter register slave
`timescale 1ns/1ps
interface dacctl_if;
  logic scl_out_ctl;
  logic scl_oe_ctl;
  logic sda_out_ctl;
  logic sda_oe_ctl;
  logic sda_out_dev;
  logic sda_oe_dev;
  logic scl_line;
  logic sda_line;
  // Open drain: any enabled low driver pulls the wire, otherwise the pull-up wins
  assign scl_line = !(scl_oe_ctl && !scl_out_ctl);
  assign sda_line = !((sda_oe_ctl && !sda_out_ctl) || (sda_oe_dev && !sda_out_dev));
  modport ctl (output scl_out_ctl, output scl_oe_ctl, output sda_out_ctl,
    output sda_oe_ctl, input scl_line, input sda_line);
  modport dev (output sda_out_dev, output sda_oe_dev, input scl_line, input sda_line);
endinterface : dacctl_if

// File: hdl/dacctl_ctl.sv
// Controller end: Wishbone slave that runs two-wire register transfers
`timescale 1ns/1ps
`include "dacctl_cfg.svh"
module dacctl_ctl (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  dacctl_if.ctl bus,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out
);
  // ==========================================================
  // Registers: 0x0 tx byte and flags, 0x4 status/rx
  // Command word: [7:0] byte, [8] start first, [9] stop after, [10] read, [11] nack on read
  logic [11:0] cmd;
  logic busy;
  logic got_nack;
  logic [7:0] rx_data;
  logic [7:0] sh;
  logic [3:0] bit_n;
  logic [`DACCTL_CNT_W-1:0] cnt;
  logic scl_o;
  logic sda_o;
  logic [2:0] sda_sync;
  dacctl_pkg::dacctl_mst_state_t state;
  wire req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire sel_cmd = (wb_adr_in == 4'h0);
  wire sel_stat = (wb_adr_in == 4'h4);
  wire do_cmd = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in && sel_cmd && wb_sel_in[0] && !busy;
  wire tick = (cnt == `DACCTL_CNT_W'(`DACCTL_HALF_CYC));
  wire [31:0] rd_word = sel_stat ? {22'h00_0000, got_nack, busy, rx_data} : {20'h0_0000, cmd};
  // Bus answer one cycle after the request
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_out <= req;
      wb_dat_out <= req ? rd_word : 32'h0000_0000;
    end
  end
  // Data line sampled through three stages
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
      sda_sync <= 3'h7;
    else
      sda_sync <= {sda_sync[1:0], bus.sda_line};
  end
  // Bit engine; half period fixed, slow enough for the slave filter
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      state <= dacctl_pkg::DACCTL_M_IDLE;
      cmd <= 12'h000;
      busy <= 1'b0;
      got_nack <= 1'b0;
      rx_data <= 8'h00;
      sh <= 8'h00;
      bit_n <= 4'h0;
      cnt <= '0;
      scl_o <= 1'b1;
      sda_o <= 1'b1;
    end
    else
    begin
      cnt <= (tick || state == dacctl_pkg::DACCTL_M_IDLE) ? '0 : `DACCTL_CNT_W'(cnt + 1'b1);
      case (state)
        dacctl_pkg::DACCTL_M_IDLE:
        begin
          if (do_cmd)
          begin
            cmd <= wb_dat_in[11:0];
            sh <= wb_dat_in[10] ? 8'hFF : wb_dat_in[7:0];
            busy <= 1'b1;
            bit_n <= 4'h0;
            state <= wb_dat_in[8] ? dacctl_pkg::DACCTL_M_START : dacctl_pkg::DACCTL_M_BIT_LOW;
          end
        end
        dacctl_pkg::DACCTL_M_START:
        begin
          // Clock up first, then data down, so a repeated start reads as a start
          if (tick && !scl_o)
            scl_o <= 1'b1;
          else if (tick && sda_o)
            sda_o <= 1'b0;
          else if (tick)
            state <= dacctl_pkg::DACCTL_M_BIT_LOW;
        end
        dacctl_pkg::DACCTL_M_BIT_LOW:
        begin
          if (tick)
          begin
            scl_o <= 1'b0;
            sda_o <= (bit_n == 4'h8) ? (!cmd[10] || cmd[11]) : sh[7];
            state <= dacctl_pkg::DACCTL_M_BIT_HIGH;
          end
        end
        dacctl_pkg::DACCTL_M_BIT_HIGH:
        begin
          if (tick)
          begin
            scl_o <= 1'b1;
            if (bit_n == 4'h8)
            begin
              got_nack <= cmd[10] ? got_nack : sda_sync[2];
              state <= cmd[9] ? dacctl_pkg::DACCTL_M_STOP_LOW : dacctl_pkg::DACCTL_M_STOP_END;
            end
            else
            begin
              sh <= {sh[6:0], 1'b1};
              rx_data <= {rx_data[6:0], sda_sync[2]};
              bit_n <= 4'(bit_n + 4'h1);
              state <= dacctl_pkg::DACCTL_M_BIT_LOW;
            end
          end
        end
        dacctl_pkg::DACCTL_M_STOP_LOW:
        begin
          if (tick)
          begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            state <= dacctl_pkg::DACCTL_M_STOP_HIGH;
          end
        end
        dacctl_pkg::DACCTL_M_STOP_HIGH:
        begin
          if (tick)
          begin
            scl_o <= 1'b1;
            state <= dacctl_pkg::DACCTL_M_STOP_END;
          end
        end
        default:
        begin
          if (tick)
          begin
            if (cmd[9])
              sda_o <= 1'b1;
            else
            begin
              scl_o <= 1'b0;
              sda_o <= 1'b1;
            end
            busy <= 1'b0;
            state <= dacctl_pkg::DACCTL_M_IDLE;
          end
        end
      endcase
    end
  end
  // Open drain drivers: enable only while pulling low
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in)
    begin
      bus.scl_out_ctl <= 1'b1;
      bus.scl_oe_ctl <= 1'b0;
      bus.sda_out_ctl <= 1'b1;
      bus.sda_oe_ctl <= 1'b0;
    end
    else
    begin
      bus.scl_out_ctl <= 1'b0;
      bus.scl_oe_ctl <= !scl_o;
      bus.sda_out_ctl <= 1'b0;
      bus.sda_oe_ctl <= !sda_o;
    end
  end
endmodule : dacctl_ctl

// File: verification/dacctl_monitor.sv
// Wire-level checker for the two-wire link between controller and converter
`timescale 1ns/1ps
module dacctl_monitor (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic scl_out_ctl,
  input wire logic scl_oe_ctl,
  input wire logic sda_out_ctl,
  input wire logic sda_oe_ctl,
  input wire logic sda_out_dev,
  input wire logic sda_oe_dev,
  input wire logic scl_line,
  input wire logic sda_line
);
  // ==========================================================
  // Helper logic
  // ==========================================================
  // Converter end pulls the data wire low
  wire logic dev_pull;
  assign dev_pull = sda_oe_dev && !sda_out_dev;
  // Counts a continuous pull; saturates so a stuck pull cannot wrap and hide
  logic [11:0] pull_cnt;
  always_ff @(posedge sys_clk_in)
  begin
    if (!resetn_in || !dev_pull)
      pull_cnt <= 12'h000;
    else if (pull_cnt != 12'hFFF)
      pull_cnt <= pull_cnt + 12'h001;
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking mon_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  scl_high_min_a : assert property (
    $rose(scl_line) |-> scl_line[*8])
    else $error("clock high pulse shorter than eight cycles");
  scl_low_min_a : assert property (
    $fell(scl_line) |-> !scl_line[*8])
    else $error("clock low pulse shorter than eight cycles");
  start_hold_a : assert property (
    $fell(sda_line) && scl_line && $past(scl_line) |-> scl_line[*8])
    else $error("start hold time shorter than eight cycles");
  start_clock_a : assert property (
    $fell(sda_line) && scl_line |-> ##[1:400] $fell(scl_line))
    else $error("no clock pulse follows a start");
  stop_free_a : assert property (
    $rose(sda_line) && scl_line && $past(scl_line) |-> (sda_line && scl_line)[*8])
    else $error("bus not left free after a stop");
  data_stable_a : assert property (
    $rose(scl_line) |-> $stable(sda_line)[*4])
    else $error("data wire moved just after clock rise");
  // A converter change while the clock is high would look like a start or stop
  dev_edge_low_a : assert property (
    $changed(dev_pull) |-> !scl_line && !$past(scl_line))
    else $error("converter moved data wire while clock high");
  // Longest legal pull is an acknowledge plus eight zero bits
  dev_pull_max_a : assert property (
    pull_cnt < 12'hC00)
    else $error("converter held data wire low too long");
endmodule : dacctl_monitor

// File: verification/audio_dac_i2c_mode_registers_bench.sv
// Bench joining controller and converter ends, driven over Wishbone
`timescale 1ns/1ps
`include "dacctl_cfg.svh"
module audio_dac_i2c_mode_registers_bench;
  // ==========================================================
  // Signals and instances
  // ==========================================================
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_dat_out;
  logic wb_ack_out;
  logic [7:0] left_atten_level_out, right_atten_level_out;
  logic [7:0] system_control_out, zero_output_control_out;
  logic [2:0] input_format_select_out;
  logic [1:0] deemph_rate_select_out, atten_speed_select_out;
  logic atten_load_enable_out, deemph_enable_out, soft_mute_out, output_phase_invert_out;
  logic converter_disable_out, bypass_stereo_select_out, rolloff_select_out, inzd;
  int miscompares = 0;
  int compares = 0;
  logic [7:0] rx;
  logic nk;
  // Straps 10: this device answers 1001110, 1001101 belongs to nobody
  localparam logic [7:0] addr_wr = {`DACCTL_ADDR_FIXED, 2'b10, 1'b0};
  localparam logic [7:0] addr_rd = {`DACCTL_ADDR_FIXED, 2'b10, 1'b1};
  localparam logic [7:0] addr_bad = {`DACCTL_ADDR_FIXED, 2'b01, 1'b0};
  // Rows for indices 10..17: [15:8] byte written, [7:0] value expected back
  logic [15:0] rows [8] = '{16'h3C3C, 16'hC3C3, 16'hA5A5, 16'h5A52,
    16'hFF7F, 16'hFE06, 16'h0002, 16'h0015};
  logic [7:0] rst_exp [6] = '{8'hFF, 8'hFF, 8'h50, 8'h00, 8'h00, 8'h01};

  always #4 sys_clk_in = ~sys_clk_in;

  dacctl_if dacctl_if_i ();
  dacctl_ctl dacctl_ctl_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .bus(dacctl_if_i.ctl), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
    .wb_adr_in(wb_adr), .wb_dat_in(wb_dat), .wb_sel_in(4'hF), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out));
  dacctl_dev dacctl_dev_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .bus(dacctl_if_i.dev), .addr_select_low_in(1'b0), .addr_select_high_in(1'b1),
    .zero_flag_in(2'b10), .device_id_in(5'h15),
    .left_atten_level_out(left_atten_level_out),
    .right_atten_level_out(right_atten_level_out),
    .atten_load_enable_out(atten_load_enable_out),
    .input_format_select_out(input_format_select_out),
    .deemph_rate_select_out(deemph_rate_select_out), .deemph_enable_out(deemph_enable_out),
    .soft_mute_out(soft_mute_out), .output_phase_invert_out(output_phase_invert_out),
    .atten_speed_select_out(atten_speed_select_out),
    .converter_disable_out(converter_disable_out),
    .bypass_stereo_select_out(bypass_stereo_select_out),
    .rolloff_select_out(rolloff_select_out), .infinite_zero_mute_out(inzd),
    .system_control_out(system_control_out), .zero_output_control_out(zero_output_control_out));
  dacctl_monitor dacctl_monitor_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .scl_out_ctl(dacctl_if_i.scl_out_ctl), .scl_oe_ctl(dacctl_if_i.scl_oe_ctl),
    .sda_out_ctl(dacctl_if_i.sda_out_ctl), .sda_oe_ctl(dacctl_if_i.sda_oe_ctl),
    .sda_out_dev(dacctl_if_i.sda_out_dev), .sda_oe_dev(dacctl_if_i.sda_oe_dev),
    .scl_line(dacctl_if_i.scl_line), .sda_line(dacctl_if_i.sda_line));

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One classic cycle; held until ack is sampled high, then released
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
    output logic [31:0] q);
    @(posedge sys_clk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    do @(posedge sys_clk_in); while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb

  // One link byte: command word, then poll status until the link is idle
  task automatic xfer(input logic [7:0] b, input logic st, input logic sp, input logic rd,
    input logic nak, output logic [7:0] rb, output logic nck);
    logic [31:0] d;
    wb(1'b1, 4'h0, {20'h0_0000, nak, rd, sp, st, b}, d);
    d = 32'h0000_0100;
    while (d[8] !== 1'b0)
      wb(1'b0, 4'h4, 32'h0000_0000, d);
    rb = d[7:0];
    nck = d[9];
  endtask : xfer

  // Mode outputs regrouped in register layout, index 10..15
  function automatic logic [7:0] port_view(input int i);
    case (i)
      0: return left_atten_level_out;
      1: return right_atten_level_out;
      2: return {atten_load_enable_out, input_format_select_out, deemph_rate_select_out,
        deemph_enable_out, soft_mute_out};
      3: return {output_phase_invert_out, atten_speed_select_out, converter_disable_out,
        1'b0, bypass_stereo_select_out, rolloff_select_out, inzd};
      4: return system_control_out;
      default: return zero_output_control_out;
    endcase
  endfunction : port_view

  task automatic check_defaults();
    for (int i = 0; i < 6; i++)
      check("reset value", rst_exp[i], port_view(i));
    check("mode 13 reset", 8'h00, port_view(3));
    check("idle lines", 8'h03, {6'h00, dacctl_if_i.scl_line, dacctl_if_i.sda_line});
  endtask : check_defaults

  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // Watchdog: full run is about 75k cycles of link traffic
  // ==========================================================
  initial
  begin
    repeat (100000) @(posedge sys_clk_in);
    miscompares++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    repeat (4) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    check_defaults();
    xfer(addr_bad, 1'b1, 1'b1, 1'b0, 1'b0, rx, nk);
    check("foreign address ack", 8'h01, {7'h00, nk});
    // Row loop: one burst write of 10..15, then one burst read of 10..17
    xfer(addr_wr, 1'b1, 1'b0, 1'b0, 1'b0, rx, nk);
    check("address ack", 8'h00, {7'h00, nk});
    xfer(8'h10, 1'b0, 1'b0, 1'b0, 1'b0, rx, nk);
    for (int i = 0; i < 6; i++)
    begin
      xfer(rows[i][15:8], 1'b0, i == 5, 1'b0, 1'b0, rx, nk);
      check("write ack", 8'h00, {7'h00, nk});
    end
    for (int i = 0; i < 6; i++)
      check("mode outputs", rows[i][7:0], port_view(i));
    xfer(addr_wr, 1'b1, 1'b0, 1'b0, 1'b0, rx, nk);
    xfer(8'h10, 1'b0, 1'b0, 1'b0, 1'b0, rx, nk);
    xfer(addr_rd, 1'b1, 1'b0, 1'b0, 1'b0, rx, nk);
    check("read address ack", 8'h00, {7'h00, nk});
    for (int i = 0; i < 8; i++)
    begin
      xfer(8'hFF, 1'b0, i == 7, 1'b1, i == 7, rx, nk);
      check("read data", rows[i][7:0], rx);
    end
    // Write aimed at a read-only index must be refused
    xfer(addr_wr, 1'b1, 1'b0, 1'b0, 1'b0, rx, nk);
    xfer(8'h16, 1'b0, 1'b0, 1'b0, 1'b0, rx, nk);
    xfer(8'h55, 1'b0, 1'b1, 1'b0, 1'b0, rx, nk);
    check("undefined write ack", 8'h01, {7'h00, nk});
    // Second reset while idle restores every mode field
    resetn_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    check_defaults();
    report_and_stop();
  end
endmodule : audio_dac_i2c_mode_registers_bench
